// File: verilog/ldc_lane_drive_regs.sv
// Per-lane swing and pre-emphasis register bank behind the two-wire port
//
// Functional notes
// - Swing code sets level: 000 resistor, +7/14/21 percent, -30/21/14/7 percent.
// - Emphasis code: 00 none, 01 3.5 dB, 10 6 dB, 11 reserved.
// - Lane fields act only with per-lane select set, else global settings.
// - Lane registers count as valid only while alternate link mode enabled.
// - Legacy mode with swap zero ignores clock emphasis writes, no emphasis.
// - Reset clears swing, emphasis and reserved bits of every lane.
// - Data lanes 0, 1, 2 at 32h, 33h, 34h; swing 7:5, emphasis 4:3.
// - Clock lane register at 31h with the same field layout.
module ldc_lane_drive_regs #(
  parameter logic [6:0] DEV_ADDR = ldc_pkg::LDC_DEV_ADDR_DEF
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic scl_pin,
  input wire logic sda_pin_in,
  output logic sda_oe_n,
  input wire ldc_pkg::ldc_mode_t mode,
  input wire ldc_pkg::ldc_drive_t global_drive,
  output ldc_pkg::ldc_drive_t [3:0] lane_drive,
  output logic [3:0][5:0] lane_swing_pct,
  output logic [3:0][3:0] lane_emph_hdb,
  output logic [3:0] lane_emph_rsv,
  output logic per_lane_active
);

  logic scl_m_r;
  logic scl_s_r;
  logic sda_m_r;
  logic sda_s_r;
  ldc_pkg::ldc_wr_t wr_req;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic [2:0] swg_r [ldc_pkg::LDC_LANES];
  logic [1:0] emp_r [ldc_pkg::LDC_LANES];
  logic [2:0] rsv_r [ldc_pkg::LDC_LANES];
  logic [1:0] wr_lane;
  logic wr_hit;
  logic [1:0] rd_lane;
  logic rd_hit;
  logic clk_emp_lock;
  logic lane_sel;
  logic emp_wr_block;
  ldc_pkg::ldc_drive_t eff [ldc_pkg::LDC_LANES];

  // Offset to lane index; the four registers sit on consecutive offsets
  function automatic logic ldc_hit(input logic [7:0] a);
    ldc_hit = (a >= ldc_pkg::LDC_OFF_CLK) && (a <= ldc_pkg::LDC_OFF_D2);
  endfunction

  function automatic logic [1:0] ldc_lane(input logic [7:0] a);
    logic [7:0] d;
    d = a - ldc_pkg::LDC_OFF_CLK;
    ldc_lane = d[1:0];
  endfunction

  // Pins are asynchronous to clk, so two flops first
  // Reset to the idle high level so no false edge follows reset
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
    end
    else
    begin
      scl_m_r <= scl_pin;
      scl_s_r <= scl_m_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
    end
    else
    begin
      sda_m_r <= sda_pin_in;
      sda_s_r <= sda_m_r;
    end
  end

  ldc_twi_target #(
    .DEV_ADDR(DEV_ADDR)
  ) u_twi (
    .clk(clk),
    .srst(srst),
    .scl_s(scl_s_r),
    .sda_s(sda_s_r),
    .sda_oe_n(sda_oe_n),
    .wr_req(wr_req),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  assign wr_hit = wr_req.wr && ldc_hit(wr_req.addr);
  assign wr_lane = ldc_lane(wr_req.addr);
  assign rd_hit = ldc_hit(rd_addr);
  assign rd_lane = ldc_lane(rd_addr);

  // Clock lane emphasis is locked in legacy mode without swap
  assign clk_emp_lock = mode.legacy_video_mode & ~mode.lane_swap_bit;

  // Lane fields only steer drive with alternate mode and lane select
  assign lane_sel = mode.alt_link_enable_bit & mode.per_lane_select_bit;

  // A locked clock lane drops only its emphasis bits, the rest still land
  assign emp_wr_block = clk_emp_lock &&
    (wr_lane == ldc_pkg::LDC_LANE_CLK);

  // Swing fields
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < ldc_pkg::LDC_LANES; i++)
        swg_r[i] <= ldc_pkg::LDC_SWG_RST;
    end
    else if (wr_hit)
    begin
      swg_r[wr_lane] <=
        wr_req.wdata[ldc_pkg::LDC_SWG_MSB:ldc_pkg::LDC_SWG_LSB];
    end
  end

  // Emphasis fields
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < ldc_pkg::LDC_LANES; i++)
        emp_r[i] <= ldc_pkg::LDC_EMP_RST;
    end
    else if (wr_hit && !emp_wr_block)
    begin
      emp_r[wr_lane] <=
        wr_req.wdata[ldc_pkg::LDC_EMP_MSB:ldc_pkg::LDC_EMP_LSB];
    end
  end

  // Reserved bits are plain storage for the host
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < ldc_pkg::LDC_LANES; i++)
        rsv_r[i] <= ldc_pkg::LDC_RSV_RST;
    end
    else if (wr_hit)
    begin
      rsv_r[wr_lane] <=
        wr_req.wdata[ldc_pkg::LDC_RSV_MSB:ldc_pkg::LDC_RSV_LSB];
    end
  end

  // Read data follows the pointer combinationally; unmapped reads zero
  always_comb
  begin
    rd_data = ldc_pkg::LDC_RD_UNMAPPED;
    if (rd_hit)
      rd_data = {swg_r[rd_lane], emp_r[rd_lane], rsv_r[rd_lane]};
  end

  // Reserved bits take no part in the drive selection
  always_comb
  begin
    for (int i = 0; i < ldc_pkg::LDC_LANES; i++)
    begin
      eff[i] = global_drive;
      if (lane_sel)
      begin
        eff[i].swing = swg_r[i];
        eff[i].emph = emp_r[i];
      end
    end
    if (clk_emp_lock)
      eff[ldc_pkg::LDC_LANE_CLK].emph = ldc_pkg::LDC_EMP_NONE;
  end

  // Drive outputs are registered so the analog side sees clean levels
  always_ff @(posedge clk)
  begin
    if (srst)
      per_lane_active <= 1'b0;
    else
      per_lane_active <= lane_sel;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      lane_drive <= '0;
    else
    begin
      for (int i = 0; i < ldc_pkg::LDC_LANES; i++)
        lane_drive[i] <= eff[i];
    end
  end

  // Decoded here once, so the analog side needs no table of its own
  always_ff @(posedge clk)
  begin
    if (srst)
      lane_swing_pct <= '0;
    else
    begin
      for (int i = 0; i < ldc_pkg::LDC_LANES; i++)
        lane_swing_pct[i] <= ldc_pkg::ldc_swing_pct(eff[i].swing);
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      lane_emph_hdb <= '0;
    else
    begin
      for (int i = 0; i < ldc_pkg::LDC_LANES; i++)
        lane_emph_hdb[i] <= ldc_pkg::ldc_emph_hdb(eff[i].emph);
    end
  end

  // The reserved code drives nothing, but the flag lets the host see it
  always_ff @(posedge clk)
  begin
    if (srst)
      lane_emph_rsv <= '0;
    else
    begin
      for (int i = 0; i < ldc_pkg::LDC_LANES; i++)
        lane_emph_rsv[i] <= (eff[i].emph == ldc_pkg::LDC_EMP_RSV);
    end
  end

endmodule

// File: common/ldc_pkg.sv
// Package for the lane drive control register bank
package ldc_pkg;

  // Register offsets on the two-wire port
  localparam logic [7:0] LDC_OFF_CLK = 8'h31;
  localparam logic [7:0] LDC_OFF_D0 = 8'h32;
  localparam logic [7:0] LDC_OFF_D1 = 8'h33;
  localparam logic [7:0] LDC_OFF_D2 = 8'h34;
  localparam logic [7:0] LDC_RD_UNMAPPED = 8'h00;

  // Lane index order: 0 clock lane, 1..3 data lanes 0..2
  localparam int LDC_LANES = 4;
  localparam logic [1:0] LDC_LANE_CLK = 2'h0;

  // Field positions inside each lane register
  localparam int LDC_SWG_MSB = 7;
  localparam int LDC_SWG_LSB = 5;
  localparam int LDC_EMP_MSB = 4;
  localparam int LDC_EMP_LSB = 3;
  localparam int LDC_RSV_MSB = 2;
  localparam int LDC_RSV_LSB = 0;

  // Reset values
  localparam logic [2:0] LDC_SWG_RST = 3'h0;
  localparam logic [1:0] LDC_EMP_RST = 2'h0;
  localparam logic [2:0] LDC_RSV_RST = 3'h0;

  // Emphasis codes
  localparam logic [1:0] LDC_EMP_NONE = 2'h0;
  localparam logic [1:0] LDC_EMP_3P5 = 2'h1;
  localparam logic [1:0] LDC_EMP_6P0 = 2'h2;
  localparam logic [1:0] LDC_EMP_RSV = 2'h3;

  // Emphasis levels in half-dB steps
  localparam logic [3:0] LDC_HDB_0 = 4'h0;
  localparam logic [3:0] LDC_HDB_3P5 = 4'h7;
  localparam logic [3:0] LDC_HDB_6P0 = 4'hc;

  // Two-wire framing
  localparam logic [3:0] LDC_BITS_BYTE = 4'h8;
  localparam logic [6:0] LDC_DEV_ADDR_DEF = 7'h2c;

  typedef struct packed {
    logic [2:0] swing;
    logic [1:0] emph;
  } ldc_drive_t;

  typedef struct packed {
    logic alt_link_enable_bit;
    logic per_lane_select_bit;
    logic lane_swap_bit;
    logic legacy_video_mode;
  } ldc_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
  } ldc_wr_t;

  // Swing code to signed percent change from the resistor-set level
  function automatic logic signed [5:0] ldc_swing_pct(input logic [2:0] c);
    case (c)
      3'h1: ldc_swing_pct = 6'sd7;
      3'h2: ldc_swing_pct = 6'sd14;
      3'h3: ldc_swing_pct = 6'sd21;
      3'h4: ldc_swing_pct = -6'sd30;
      3'h5: ldc_swing_pct = -6'sd21;
      3'h6: ldc_swing_pct = -6'sd14;
      3'h7: ldc_swing_pct = -6'sd7;
      default: ldc_swing_pct = 6'sd0;
    endcase
  endfunction

  // Emphasis code to level; the reserved code drives no emphasis
  function automatic logic [3:0] ldc_emph_hdb(input logic [1:0] c);
    case (c)
      LDC_EMP_3P5: ldc_emph_hdb = LDC_HDB_3P5;
      LDC_EMP_6P0: ldc_emph_hdb = LDC_HDB_6P0;
      default: ldc_emph_hdb = LDC_HDB_0;
    endcase
  endfunction

endpackage

// File: verilog/ldc_twi_target.sv
// Two-wire register port target: byte pointer, writes and reads
module ldc_twi_target #(
  parameter logic [6:0] DEV_ADDR = ldc_pkg::LDC_DEV_ADDR_DEF
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic scl_s,
  input wire logic sda_s,
  output logic sda_oe_n,
  output ldc_pkg::ldc_wr_t wr_req,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);

  typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_REG, ST_WR, ST_RD} ldc_tst_t;

  ldc_tst_t state_r;
  logic scl_d_r;
  logic sda_d_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic ack_r;
  logic rnw_r;
  logic [7:0] ptr_r;
  logic drv_low_r;
  logic start_c;
  logic stop_c;
  logic rise_c;
  logic fall_c;
  logic byte_done_c;

  // Inputs here are already synchronised; these delays only find edges
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign start_c = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_c = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign rise_c = scl_s & ~scl_d_r;
  assign fall_c = ~scl_s & scl_d_r;
  assign byte_done_c = (cnt_r == ldc_pkg::LDC_BITS_BYTE);
  assign sda_oe_n = ~drv_low_r;
  assign rd_addr = ptr_r;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      ack_r <= 1'b0;
      rnw_r <= 1'b0;
      ptr_r <= 8'h00;
      drv_low_r <= 1'b0;
      wr_req <= '0;
    end
    else
    begin
      wr_req.wr <= 1'b0;
      if (start_c)
      begin
        state_r <= ST_DEV;
        cnt_r <= 4'h0;
        ack_r <= 1'b0;
        drv_low_r <= 1'b0;
      end
      else if (stop_c)
      begin
        state_r <= ST_IDLE;
        drv_low_r <= 1'b0;
      end
      else
      begin
        case (state_r)
          ST_IDLE:
          begin
            drv_low_r <= 1'b0;
          end
          ST_DEV, ST_REG, ST_WR:
          begin
            if (rise_c && !byte_done_c)
            begin
              sh_r <= {sh_r[6:0], sda_s};
              cnt_r <= cnt_r + 4'h1;
            end
            else if (fall_c && byte_done_c && !ack_r)
            begin
              ack_r <= 1'b1;
              if (state_r != ST_DEV || sh_r[7:1] == DEV_ADDR)
                drv_low_r <= 1'b1;
              else
                state_r <= ST_IDLE;
              if (state_r == ST_DEV)
                rnw_r <= sh_r[0];
              else if (state_r == ST_REG)
                ptr_r <= sh_r;
              else
              begin
                wr_req.addr <= ptr_r;
                wr_req.wdata <= sh_r;
                wr_req.wr <= 1'b1;
              end
            end
            else if (fall_c && ack_r)
            begin
              ack_r <= 1'b0;
              cnt_r <= 4'h0;
              if (state_r == ST_WR)
                ptr_r <= ptr_r + 8'h01;
              if (state_r == ST_DEV && rnw_r)
              begin
                state_r <= ST_RD;
                sh_r <= rd_data;
                drv_low_r <= ~rd_data[7];
              end
              else
              begin
                drv_low_r <= 1'b0;
                state_r <= (state_r == ST_DEV) ? ST_REG : ST_WR;
              end
            end
          end
          ST_RD:
          begin
            // Master acknowledge: a high level ends the read burst
            if (rise_c && byte_done_c)
            begin
              if (sda_s)
                state_r <= ST_IDLE;
              else
                ack_r <= 1'b1;
            end
            else if (rise_c)
              cnt_r <= cnt_r + 4'h1;
            else if (fall_c && byte_done_c && !ack_r)
            begin
              // Last bit is out; free the line for the master's answer
              drv_low_r <= 1'b0;
              ptr_r <= ptr_r + 8'h01;
            end
            else if (fall_c && byte_done_c)
            begin
              ack_r <= 1'b0;
              cnt_r <= 4'h0;
              sh_r <= rd_data;
              drv_low_r <= ~rd_data[7];
            end
            else if (fall_c)
            begin
              drv_low_r <= ~sh_r[6];
              sh_r <= {sh_r[6:0], 1'b0};
            end
          end
          default:
          begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// File: verification/ldc_host.sv
// Two-wire host model that drives the register port of the bank
module ldc_host (
  input wire logic clk,
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Long half period keeps every edge clear of the pin synchronisers
  task automatic hp;
    repeat (8) @(posedge clk);
  endtask
  task automatic start;
    sda_drv <= 1'b1;
    hp;
    scl <= 1'b1;
    hp;
    sda_drv <= 1'b0;
    hp;
    scl <= 1'b0;
    hp;
  endtask
  task automatic stop;
    sda_drv <= 1'b0;
    hp;
    scl <= 1'b1;
    hp;
    sda_drv <= 1'b1;
    hp;
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_drv <= b;
    hp;
    scl <= 1'b1;
    hp;
    r = sda;
    scl <= 1'b0;
    hp;
  endtask
  // Data goes out msb first; the ninth bit carries the acknowledge
  task automatic xfer(input logic [7:0] d, input logic ai,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ai, ack);
  endtask
endmodule

// File: verification/ldc_lane_drive_regs_asserts.sv
// Port assertions for the lane drive control register bank
module ldc_lane_drive_regs_asserts (
  input wire logic clk,
  input wire logic srst,
  input wire logic scl_pin,
  input wire logic sda_oe_n,
  input wire ldc_pkg::ldc_mode_t mode,
  input wire ldc_pkg::ldc_drive_t global_drive,
  input wire ldc_pkg::ldc_drive_t [3:0] lane_drive,
  input wire logic [3:0][5:0] lane_swing_pct,
  input wire logic [3:0][3:0] lane_emph_hdb,
  input wire logic [3:0] lane_emph_rsv,
  input wire logic per_lane_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  localparam logic [47:0] PCT = 48'he72a_e254_e1c0;
  localparam logic [15:0] HDB = 16'h0c70;
  logic sel, swg_ok, emp_ok, rsv_ok;
  assign sel = mode.alt_link_enable_bit && mode.per_lane_select_bit;
  always_comb
  begin
    swg_ok = 1'b1;
    emp_ok = 1'b1;
    rsv_ok = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      swg_ok &= lane_swing_pct[i] == PCT[6*lane_drive[i].swing +: 6];
      emp_ok &= lane_emph_hdb[i] == HDB[4*lane_drive[i].emph +: 4];
      rsv_ok &= lane_emph_rsv[i] == (lane_drive[i].emph == 2'h3);
    end
  end
  sequence s_oe_move;
    $changed(sda_oe_n);
  endsequence
  a_active_sel: assert property (!$past(srst) |->
    per_lane_active == $past(sel)) else $error("per-lane flag wrong");
  a_global_data: assert property (!$past(srst) && !$past(sel) |->
    lane_drive[3:1] == {3{$past(global_drive)}})
    else $error("data lanes ignore global");
  a_global_clk: assert property (!$past(srst) && !$past(sel) |->
    lane_drive[0].swing == $past(global_drive.swing))
    else $error("clock lane swing ignores global");
  a_clk_emph_off: assert property (!$past(srst) &&
    $past(mode.legacy_video_mode && !mode.lane_swap_bit) |->
    lane_drive[0].emph == 2'h0) else $error("clock emphasis in legacy");
  a_swing_map: assert property (swg_ok)
    else $error("swing percent mismatch");
  a_emph_map: assert property (emp_ok)
    else $error("emphasis level mismatch");
  a_rsv_flag: assert property (rsv_ok)
    else $error("reserved emphasis flag mismatch");
  a_reset_clear: assert property ($past(srst) |->
    lane_drive == '0 && !per_lane_active && sda_oe_n)
    else $error("outputs not cleared by reset");
  a_sda_scl_low: assert property (s_oe_move |-> !scl_pin)
    else $error("data pin moved while clock high");
endmodule
bind ldc_lane_drive_regs ldc_lane_drive_regs_asserts i_chk (
  .clk, .srst, .scl_pin, .sda_oe_n, .mode, .global_drive, .lane_drive,
  .lane_swing_pct, .lane_emph_hdb, .lane_emph_rsv, .per_lane_active
);

// File: verification/tb.sv
// Testbench for the lane drive control register bank
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] DA = 7'h2c;
  localparam logic [47:0] PCT = 48'he72a_e254_e1c0;
  localparam logic [15:0] HDB = 16'h0c70;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic scl, sda_drv, sda_oe_n, per_lane_active, a;
  ldc_pkg::ldc_mode_t mode = '0;
  ldc_pkg::ldc_drive_t global_drive = '0;
  ldc_pkg::ldc_drive_t [3:0] lane_drive;
  logic [3:0][5:0] lane_swing_pct;
  logic [3:0][3:0] lane_emph_hdb;
  logic [3:0] lane_emph_rsv;
  logic [7:0] q;
  logic [7:0] regs [4];
  int fails = 0;
  int total_checks = 0;
  // Open-drain line with pull-up: any low enable wins
  wire sda = sda_drv & sda_oe_n;
  always #2 clk = ~clk;
  ldc_lane_drive_regs #(.DEV_ADDR(DA)) i_ldc_lane_drive_regs (
    .clk, .srst, .scl_pin(scl), .sda_pin_in(sda), .sda_oe_n, .mode,
    .global_drive, .lane_drive, .lane_swing_pct, .lane_emph_hdb,
    .lane_emph_rsv, .per_lane_active
  );
  ldc_host i_ldc_host (.clk, .scl, .sda_drv, .sda);
  task automatic check(string n, logic [7:0] s, logic [7:0] e);
    total_checks++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic xb(logic [7:0] d);
    i_ldc_host.xfer(d, 1'b1, q, a);
    check("ack", 8'(a), 8'h00);
  endtask
  task automatic wr(logic [7:0] o, logic [7:0] d);
    i_ldc_host.start;
    xb({DA, 1'b0});
    xb(o);
    xb(d);
    i_ldc_host.stop;
  endtask
  task automatic rd(logic [7:0] o);
    i_ldc_host.start;
    xb({DA, 1'b0});
    xb(o);
    i_ldc_host.start;
    xb({DA, 1'b1});
    i_ldc_host.xfer(8'hff, 1'b1, q, a);
    i_ldc_host.stop;
  endtask
  task automatic md(logic [3:0] m);
    @(posedge clk);
    mode <= m;
    repeat (3) @(posedge clk);
  endtask
  task automatic results;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge clk);
    fails++;
    results;
  end
  initial
  begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 4; i++)
    begin
      rd(ldc_pkg::LDC_OFF_CLK + 8'(i));
      check("reset reg", q, 8'h00);
    end
    md(4'b1100);
    check("active", 8'(per_lane_active), 8'h01);
    for (int k = 0; k < 2; k++)
    begin
      for (int i = 0; i < 4; i++)
      begin
        regs[i] = {3'(i + 4 * k), 2'(i + 1), 3'(7 - i - k)};
        wr(ldc_pkg::LDC_OFF_CLK + 8'(i), regs[i]);
      end
      for (int i = 0; i < 4; i++)
      begin
        rd(ldc_pkg::LDC_OFF_CLK + 8'(i));
        check("readback", q, regs[i]);
        check("drive", 8'(lane_drive[i]), 8'(regs[i][7:3]));
        check("pct", 8'(lane_swing_pct[i]),
              8'(PCT[6*regs[i][7:5] +: 6]));
        check("hdb", 8'(lane_emph_hdb[i]),
              8'(HDB[4*regs[i][4:3] +: 4]));
        check("rsv", 8'(lane_emph_rsv[i]),
              8'(regs[i][4:3] == 2'h3));
      end
    end
    global_drive <= 5'h16;
    for (int m = 8; m >= 4; m -= 4)
    begin
      md(4'(m));
      check("active", 8'(per_lane_active), 8'h00);
      for (int i = 0; i < 4; i++)
        check("global", 8'(lane_drive[i]), 8'h16);
    end
    md(4'b1101);
    wr(ldc_pkg::LDC_OFF_CLK, 8'hd7);
    rd(ldc_pkg::LDC_OFF_CLK);
    check("legacy reg", q, 8'hcf);
    check("legacy drive", 8'(lane_drive[0]), 8'h18);
    md(4'b1110);
    check("swap drive", 8'(lane_drive[0]), 8'h19);
    wr(8'h35, 8'hff);
    rd(8'h35);
    check("unmapped", q, 8'h00);
    i_ldc_host.start;
    i_ldc_host.xfer({DA ^ 7'h01, 1'b0}, 1'b1, q, a);
    check("nack", 8'(a), 8'h01);
    i_ldc_host.stop;
    results;
  end
endmodule
